// [inc/pis_pkg.sv]
`default_nettype none
package pis_pkg;
  // backplane and slot select
  localparam int unsigned PIS_NLINES = 8;
  localparam int unsigned PIS_SLOT_W = 3;
  localparam int unsigned PIS_NPINS  = 2;
  // register map (byte addresses)
  localparam int unsigned PIS_AW       = 8;
  localparam logic [7:0]  PIS_OFF_CTRL = 8'h00;
  localparam logic [7:0]  PIS_OFF_CMD  = 8'h04;
  localparam logic [7:0]  PIS_OFF_STAT = 8'h08;
  // control register fields
  localparam int unsigned PIS_CTRL_CTRL_OP = 0;
  localparam int unsigned PIS_CTRL_IRQ_OP  = 1;
  localparam int unsigned PIS_CTRL_EDGE    = 2;
  localparam int unsigned PIS_CTRL_PRESENT = 3;
  localparam int unsigned PIS_CTRL_SLOT    = 4;
  localparam logic        PIS_PRESENT_RST  = 1'b1;
  // command register fields (write-one pulses)
  localparam int unsigned PIS_CMD_DISABLE = 0;
  localparam int unsigned PIS_CMD_ENABLE  = 1;
  localparam int unsigned PIS_CMD_DELAY   = 2;
  // status register fields
  localparam int unsigned PIS_STAT_LVL  = 0;
  localparam int unsigned PIS_STAT_RET  = 3;
  localparam int unsigned PIS_STAT_REQ  = 6;
  localparam int unsigned PIS_STAT_LINE = 7;
  localparam int unsigned PIS_STAT_GATE = 8;
  localparam int unsigned PIS_STAT_HPND = 10;
  // bus responses
  localparam logic [1:0]  PIS_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PIS_RESP_SLVERR = 2'h2;
  // program levels and interrupt gate
  typedef enum logic [2:0] {
    PIS_LVL_CYCLIC,
    PIS_LVL_CTRL,
    PIS_LVL_SVC,
    PIS_LVL_DELAY,
    PIS_LVL_HALT
  } pis_level_t;
  typedef enum logic [1:0] {
    PIS_GATE_ON,
    PIS_GATE_DELAY,
    PIS_GATE_OFF
  } pis_gate_t;
endpackage
`default_nettype wire

// [rtl/pis_line_sync.sv]
`default_nettype none
module pis_line_sync #(
  parameter int unsigned NL = 8,
  parameter int unsigned SW = 3,
  parameter int unsigned NX = 2
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // raw pins
  input  wire logic [NL-1:0] lines,
  input  wire logic [NX-1:0] ext,
  input  wire logic [SW-1:0] sel,
  // synchronised view
  output logic               line_lvl,
  output logic               line_rise,
  output logic [NX-1:0]      ext_lvl
);
  typedef struct packed {
    logic [NL+NX-1:0] s1;
    logic [NL+NX-1:0] s2;
    logic             lvl;
    logic             rise;
  } pis_sync_t;

  pis_sync_t q;
  pis_sync_t n;

  // only the slot's own line is watched; s1 feeds s2 alone
  always_comb begin
    n      = q;
    n.s1   = {ext, lines};
    n.s2   = q.s1;
    n.lvl  = q.s2[sel];
    n.rise = q.s2[sel] & ~q.lvl;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign line_lvl  = q.lvl;
  assign line_rise = q.rise;
  assign ext_lvl   = q.s2[NL +: NX];
endmodule // pis_line_sync
`default_nettype wire

// [rtl/pis_sequencer.sv]
// Function
// - closed-loop task yields at block, or operation, boundaries as set.
// - pending process or delay interrupt pre-empts closed-loop task.
// - fault, error or operator action halts at next operation boundary.
// - stop instruction halts the running task at an operation boundary.
// - active assigned backplane line raises a process interrupt request.
// - exactly one line is watched, chosen by the rack slot.
// - line evaluation is selectable, level or edge.
// - software can disable, delay and re-enable the process interrupt.
// - service routine is inserted at operation or block boundary as set.
// - accepting the request starts the one service routine.
// - with no service routine present, nothing is interrupted.
// - on routine end, the interrupted level resumes where it stopped.
// - errors may suspend the service routine, only at operation boundary.
// - service routine yields only to errors, operator or stop.
// - timed tasks and further interrupts never pre-empt the routine.
// - level mode: active line sets request served at next boundary.
// - edge mode: after routine end only a rising edge re-requests.
// - activations during service are neither counted nor flagged.
// - between disable and enable no interrupt-driven execution occurs.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`default_nettype none
module pis_sequencer
  import pis_pkg::*;
#(
  parameter int unsigned NLINES = PIS_NLINES
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // axi4-lite write address and data
  input  wire logic [PIS_AW-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [PIS_AW-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // backplane and operator pins
  input  wire logic [NLINES-1:0]    irq_lines,
  input  wire logic                 stop_switch,
  input  wire logic                 multiprocessor_halt,
  // events from the program sequencer
  input  wire logic                 block_boundary,
  input  wire logic                 op_boundary,
  input  wire logic                 ctrl_due,
  input  wire logic                 delay_irq_req,
  input  wire logic                 level_done,
  input  wire logic                 halt_release,
  input  wire logic                 hw_fault,
  input  wire logic                 prog_error,
  input  wire logic                 programmer_device_req,
  input  wire logic                 stop_instr,
  // orders to the program sequencer
  output logic                      dispatch,
  output logic                      resume,
  output logic                      halt,
  output pis_pkg::pis_level_t       cur_level
);
  import pis_pkg::*;

  typedef struct packed {
    pis_level_t             lvl;
    pis_level_t             ret;
    pis_level_t             hret;
    logic                   halt_pend;
    logic                   req;
    pis_gate_t              gate;
    logic                   ctrl_op;
    logic                   irq_op;
    logic                   edge_mode;
    logic                   present;
    logic [PIS_SLOT_W-1:0]  slot;
    logic                   dispatch;
    logic                   resume;
    logic                   halt;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
  } pis_state_t;

  pis_state_t q;
  pis_state_t n;

  logic                 line_lvl;
  logic                 line_rise;
  logic [PIS_NPINS-1:0] pin_lvl;
  logic                 wr_go;
  logic                 rd_go;
  logic                 fault_ev;
  logic                 take_irq;
  logic                 set_req;

  // a block boundary is always an operation boundary as well
  function automatic logic at_bnd(input logic op_sel,
                                  input logic op_b,
                                  input logic blk_b);
    at_bnd = blk_b | (op_sel & op_b);
  endfunction

  function automatic logic [31:0] stat_word(input pis_state_t s,
                                            input logic lv);
    stat_word = '0;
    stat_word[PIS_STAT_LVL +: $bits(pis_level_t)] = s.lvl;
    stat_word[PIS_STAT_RET +: $bits(pis_level_t)] = s.ret;
    stat_word[PIS_STAT_REQ]       = s.req;
    stat_word[PIS_STAT_LINE]      = lv;
    stat_word[PIS_STAT_GATE +: $bits(pis_gate_t)] = s.gate;
    stat_word[PIS_STAT_HPND]      = s.halt_pend;
  endfunction

  pis_line_sync #(
    .NL (NLINES),
    .SW (PIS_SLOT_W),
    .NX (PIS_NPINS)
  ) u_sync (
    .clk       (clk),
    .rst_b     (rst_b),
    .lines     (irq_lines),
    .ext       ({multiprocessor_halt, stop_switch}),
    .sel       (q.slot),
    .line_lvl  (line_lvl),
    .line_rise (line_rise),
    .ext_lvl   (pin_lvl)
  );

  // write taken only with address and data together and no answer owed
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
  assign rd_go = s_axi_arvalid & ~q.rvalid;

  assign fault_ev = hw_fault | prog_error | programmer_device_req
                  | stop_instr | (|pin_lvl);
  assign take_irq = q.req & q.present
                  & (q.gate == PIS_GATE_ON);

  always_comb begin
    n          = q;
    n.dispatch = 1'b0;
    n.resume   = 1'b0;
    n.halt     = 1'b0;
    set_req    = 1'b0;

    if (fault_ev && q.lvl != PIS_LVL_HALT) begin
      n.halt_pend = 1'b1;
    end

    case (q.lvl)
      PIS_LVL_HALT: begin
        // a held stop pin keeps the level parked
        if (halt_release && !(|pin_lvl)) begin
          n.lvl    = q.hret;
          n.resume = 1'b1;
        end
      end
      default: begin
        if (q.halt_pend && at_bnd(1'b1, op_boundary, block_boundary)) begin
          n.hret      = q.lvl;
          n.lvl       = PIS_LVL_HALT;
          n.halt      = 1'b1;
          n.halt_pend = 1'b0;
        end else begin
          case (q.lvl)
            PIS_LVL_CYCLIC: begin
              if (take_irq &&
                  at_bnd(q.irq_op, op_boundary, block_boundary)) begin
                n.ret      = PIS_LVL_CYCLIC;
                n.lvl      = PIS_LVL_SVC;
                n.req      = 1'b0;
                n.dispatch = 1'b1;
              end else if (ctrl_due &&
                  at_bnd(q.ctrl_op, op_boundary, block_boundary)) begin
                n.lvl      = PIS_LVL_CTRL;
                n.dispatch = 1'b1;
              end
            end
            PIS_LVL_CTRL: begin
              if (take_irq &&
                  at_bnd(q.ctrl_op, op_boundary, block_boundary)) begin
                n.ret      = PIS_LVL_CTRL;
                n.lvl      = PIS_LVL_SVC;
                n.req      = 1'b0;
                n.dispatch = 1'b1;
              end else if (delay_irq_req &&
                  at_bnd(q.ctrl_op, op_boundary, block_boundary)) begin
                n.ret      = PIS_LVL_CTRL;
                n.lvl      = PIS_LVL_DELAY;
                n.dispatch = 1'b1;
              end else if (level_done) begin
                n.lvl    = PIS_LVL_CYCLIC;
                n.resume = 1'b1;
              end
            end
            PIS_LVL_SVC, PIS_LVL_DELAY: begin
              // nothing but a halt pre-empts these levels
              if (level_done) begin
                n.lvl    = q.ret;
                n.resume = 1'b1;
              end
            end
            default: begin
              n.lvl = PIS_LVL_CYCLIC;
            end
          endcase
        end
      end
    endcase

    // a fault landing as a halt is taken stays pending: set wins
    if (q.lvl != PIS_LVL_HALT && n.lvl == PIS_LVL_HALT &&
        (hw_fault | prog_error | programmer_device_req | stop_instr)) begin
      n.halt_pend = 1'b1;
    end

    // line activity while the routine runs, or as it starts, is dropped
    if (n.lvl != PIS_LVL_SVC && q.lvl != PIS_LVL_SVC &&
        q.present && q.gate != PIS_GATE_OFF) begin
      set_req = q.edge_mode ? line_rise : line_lvl;
    end
    if (set_req) begin
      n.req = 1'b1;
    end

    // register writes
    if (wr_go) begin
      n.bvalid = 1'b1;
      n.bresp  = PIS_RESP_OKAY;
      case (s_axi_awaddr)
        PIS_OFF_CTRL: begin
          if (s_axi_wstrb[0]) begin
            n.ctrl_op   = s_axi_wdata[PIS_CTRL_CTRL_OP];
            n.irq_op    = s_axi_wdata[PIS_CTRL_IRQ_OP];
            n.edge_mode = s_axi_wdata[PIS_CTRL_EDGE];
            n.present   = s_axi_wdata[PIS_CTRL_PRESENT];
            n.slot      = s_axi_wdata[PIS_CTRL_SLOT +: PIS_SLOT_W];
          end
        end
        PIS_OFF_CMD: begin
          if (s_axi_wstrb[0]) begin
            // disable outranks the others in one write
            if (s_axi_wdata[PIS_CMD_DISABLE]) begin
              n.gate = PIS_GATE_OFF;
              n.req  = 1'b0;
            end else if (s_axi_wdata[PIS_CMD_DELAY]) begin
              n.gate = PIS_GATE_DELAY;
            end else if (s_axi_wdata[PIS_CMD_ENABLE]) begin
              n.gate = PIS_GATE_ON;
            end
          end
        end
        PIS_OFF_STAT: begin
          n.bresp = PIS_RESP_OKAY;
        end
        default: begin
          n.bresp = PIS_RESP_SLVERR;
        end
      endcase
    end else if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // register reads
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rresp  = PIS_RESP_OKAY;
      n.rdata  = '0;
      case (s_axi_araddr)
        PIS_OFF_CTRL: begin
          n.rdata[PIS_CTRL_CTRL_OP]            = q.ctrl_op;
          n.rdata[PIS_CTRL_IRQ_OP]             = q.irq_op;
          n.rdata[PIS_CTRL_EDGE]               = q.edge_mode;
          n.rdata[PIS_CTRL_PRESENT]            = q.present;
          n.rdata[PIS_CTRL_SLOT +: PIS_SLOT_W] = q.slot;
        end
        PIS_OFF_CMD: begin
          n.rdata = '0;
        end
        PIS_OFF_STAT: begin
          n.rdata = stat_word(q, line_lvl);
        end
        default: begin
          n.rresp = PIS_RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q         <= '0;
      q.present <= PIS_PRESENT_RST;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;
  assign dispatch      = q.dispatch;
  assign resume        = q.resume;
  assign halt          = q.halt;
  assign cur_level     = q.lvl;
endmodule // pis_sequencer
`default_nettype wire

// [tb/pis_irq_src.sv]
`default_nettype none
module pis_irq_src (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // what the module asserts
  input  wire logic [2:0] slot,
  input  wire logic       lvl,
  input  wire logic [7:0] noise,
  // backplane lines
  output logic      [7:0] irq_lines
);
  // foreign lines carry noise so only the assigned line can matter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_lines <= 8'h00;
    end else begin
      irq_lines       <= noise;
      irq_lines[slot] <= lvl;
    end
  end
endmodule // pis_irq_src
`default_nettype wire

// [tb/pis_seq_chk.sv]
`default_nettype none
module pis_seq_chk
  import pis_pkg::*;
(
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_b,
  // sequencer events
  input wire logic                block_boundary,
  input wire logic                op_boundary,
  input wire logic                ctrl_due,
  input wire logic                delay_irq_req,
  input wire logic                level_done,
  // orders
  input wire logic                dispatch,
  input wire logic                resume,
  input wire logic                halt,
  input wire pis_pkg::pis_level_t cur_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_svc_hold: assert property (
    $past(cur_level) == PIS_LVL_SVC && cur_level != PIS_LVL_SVC
      |-> resume || halt) else $error("routine left without cause");
  a_halt_bound: assert property (
    halt |-> $past(op_boundary || block_boundary))
    else $error("halt off a boundary");
  a_halt_level: assert property (
    halt |-> cur_level == PIS_LVL_HALT) else $error("halt level wrong");
  a_ctrl_start: assert property (
    dispatch && cur_level == PIS_LVL_CTRL
      |-> $past(ctrl_due && (block_boundary || op_boundary)))
    else $error("control task started without cause");
  a_svc_start: assert property (
    dispatch && cur_level == PIS_LVL_SVC
      |-> $past(block_boundary || op_boundary)
          && $past(cur_level) != PIS_LVL_SVC)
    else $error("routine started off a boundary");
  a_delay_start: assert property (
    dispatch && cur_level == PIS_LVL_DELAY
      |-> $past(cur_level) == PIS_LVL_CTRL && $past(delay_irq_req))
    else $error("delay level started wrongly");
  a_resume_cause: assert property (
    resume && $past(cur_level) != PIS_LVL_HALT |-> $past(level_done))
    else $error("resume without level end");
  a_level_order: assert property (
    cur_level != $past(cur_level) |-> dispatch || resume || halt)
    else $error("level changed without order");
endmodule // pis_seq_chk
bind pis_sequencer pis_seq_chk chk_u (.clk, .rst_b, .block_boundary,
  .op_boundary, .ctrl_due, .delay_irq_req, .level_done, .dispatch, .resume,
  .halt, .cur_level);
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pis_pkg::*;
  localparam logic [2:0] NO = 3'h0, DS = 3'h4, RS = 3'h2, HL = 3'h1;
  localparam logic [7:0] BK = 8'h01, OP = 8'h02, DN = 8'h04, RL = 8'h08;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, irq_lines, noise, ev;
  logic [31:0] s_axi_wdata, s_axi_rdata, ctrl_v, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, clk, rst_b, lvl;
  logic        stop_switch, multiprocessor_halt, ctrl_due, delay_irq_req;
  logic        dispatch, resume, halt;
  logic [2:0]  slot;
  pis_level_t  cur_level;
  int          failures, comparisons, k;
  pis_sequencer dut_u (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq_lines, .stop_switch, .multiprocessor_halt, .block_boundary(ev[0]),
    .op_boundary(ev[1] | ev[0]), .ctrl_due, .delay_irq_req,
    .level_done(ev[2]), .halt_release(ev[3]), .hw_fault(ev[6]),
    .prog_error(ev[5]), .programmer_device_req(ev[7]), .stop_instr(ev[4]),
    .dispatch, .resume, .halt, .cur_level);
  pis_irq_src src_u (.clk, .rst_b, .slot, .lvl, .noise, .irq_lines);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    @(posedge clk iff s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    @(posedge clk iff s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(posedge clk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge clk iff s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // one cycle of sequencer events; the orders they cause still stand
  // at the following edge, where they are sampled
  task automatic step(input logic [7:0] e, input logic [2:0] o,
                      input pis_level_t l);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 8'h00;
    @(posedge clk);
    chk({29'h0, dispatch, resume, halt}, {29'h0, o});
    chk({29'h0, cur_level}, {29'h0, l});
  endtask
  // line passes four flops, source and synchroniser, so six cycles leave margin
  task automatic rise();
    @(posedge clk);
    lvl   <= 1'b0;
    noise <= 8'($urandom);
    repeat (6) @(posedge clk);
    lvl <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic clr();
    wr(PIS_OFF_CMD, 32'h1);
    wr(PIS_OFF_CMD, 32'h2);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12000) @(posedge clk);
    failures++;
    wrap_up();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, lvl, stop_switch, multiprocessor_halt} = 4'h0;
    {ctrl_due, delay_irq_req, ev, noise} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    rst_b = 1'b0;
    void'($urandom(52225));
    slot   = 3'($urandom);
    ctrl_v = 32'h08 | (32'(slot) << 4);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rc(PIS_OFF_CTRL, 32'h08, PIS_RESP_OKAY);
    rc(PIS_OFF_STAT, 32'h0, PIS_RESP_OKAY);
    rc(8'h0c, 32'h0, PIS_RESP_SLVERR);
    wr(PIS_OFF_STAT, 32'hffff);
    chk({30'h0, r}, {30'h0, PIS_RESP_OKAY});
    wr(8'h0c, 32'h1);
    chk({30'h0, r}, {30'h0, PIS_RESP_SLVERR});
    rc(PIS_OFF_CMD, 32'h0, PIS_RESP_OKAY);
    wr(PIS_OFF_CTRL, ctrl_v);
    rc(PIS_OFF_CTRL, ctrl_v, PIS_RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(PIS_OFF_CTRL, 32'h0);
    chk({30'h0, r}, {30'h0, PIS_RESP_OKAY});
    s_axi_wstrb <= 4'hf;
    rc(PIS_OFF_CTRL, ctrl_v, PIS_RESP_OKAY);
    $display("test registers done");
    noise <= 8'hff;
    repeat (6) @(posedge clk);
    rc(PIS_OFF_STAT, 32'h0, PIS_RESP_OKAY);
    lvl <= 1'b1;
    repeat (6) @(posedge clk);
    rc(PIS_OFF_STAT, 32'hc0, PIS_RESP_OKAY);
    step(BK, DS, PIS_LVL_SVC);
    ctrl_due      <= 1'b1;
    delay_irq_req <= 1'b1;
    step(BK, NO, PIS_LVL_SVC);
    ctrl_due      <= 1'b0;
    delay_irq_req <= 1'b0;
    step(DN, RS, PIS_LVL_CYCLIC);
    step(BK, DS, PIS_LVL_SVC);
    lvl <= 1'b0;
    step(DN, RS, PIS_LVL_CYCLIC);
    clr();
    $display("test level mode done");
    wr(PIS_OFF_CTRL, ctrl_v | 32'h4);
    clr();
    rise();
    step(OP, NO, PIS_LVL_CYCLIC);
    step(BK, DS, PIS_LVL_SVC);
    step(DN, RS, PIS_LVL_CYCLIC);
    step(BK, NO, PIS_LVL_CYCLIC);
    wr(PIS_OFF_CTRL, ctrl_v | 32'h6);
    rise();
    step(OP, DS, PIS_LVL_SVC);
    step(DN, RS, PIS_LVL_CYCLIC);
    $display("test edge mode done");
    wr(PIS_OFF_CMD, 32'h7);
    rise();
    step(BK, NO, PIS_LVL_CYCLIC);
    rc(PIS_OFF_STAT, 32'h280, PIS_RESP_OKAY);
    wr(PIS_OFF_CMD, 32'h2);
    rise();
    step(OP, DS, PIS_LVL_SVC);
    step(DN, RS, PIS_LVL_CYCLIC);
    wr(PIS_OFF_CMD, 32'h6);
    rise();
    step(BK, NO, PIS_LVL_CYCLIC);
    rc(PIS_OFF_STAT, 32'h1c0, PIS_RESP_OKAY);
    wr(PIS_OFF_CMD, 32'h2);
    step(OP, DS, PIS_LVL_SVC);
    step(DN, RS, PIS_LVL_CYCLIC);
    wr(PIS_OFF_CTRL, (ctrl_v ^ 32'h8) | 32'h6);
    rise();
    step(BK, NO, PIS_LVL_CYCLIC);
    wr(PIS_OFF_CTRL, ctrl_v | 32'h6);
    clr();
    $display("test gate done");
    ctrl_due <= 1'b1;
    step(OP, NO, PIS_LVL_CYCLIC);
    step(BK, DS, PIS_LVL_CTRL);
    ctrl_due      <= 1'b0;
    delay_irq_req <= 1'b1;
    step(OP, NO, PIS_LVL_CTRL);
    wr(PIS_OFF_CTRL, ctrl_v | 32'h7);
    step(OP, DS, PIS_LVL_DELAY);
    delay_irq_req <= 1'b0;
    step(DN, RS, PIS_LVL_CTRL);
    rise();
    step(OP, DS, PIS_LVL_SVC);
    step(8'h20, NO, PIS_LVL_SVC);
    repeat (4) @(posedge clk);
    step(BK, HL, PIS_LVL_HALT);
    step(RL, RS, PIS_LVL_SVC);
    step(DN, RS, PIS_LVL_CTRL);
    for (k = 4; k < 8; k++) begin
      step(8'(1 << k), NO, PIS_LVL_CTRL);
      repeat (4) @(posedge clk);
      step(OP, HL, PIS_LVL_HALT);
      step(RL, RS, PIS_LVL_CTRL);
    end
    // operator pins last: while either stays high a halt release is refused and the level stays parked
    for (k = 0; k < 2; k++) begin
      {multiprocessor_halt, stop_switch} <= 2'(1 << k);
      repeat (5) @(posedge clk);
      step(OP, HL, PIS_LVL_HALT);
      step(RL, NO, PIS_LVL_HALT);
      {multiprocessor_halt, stop_switch} <= 2'h0;
      repeat (5) @(posedge clk);
      step(RL, RS, PIS_LVL_CTRL);
    end
    step(DN, RS, PIS_LVL_CYCLIC);
    $display("test control and halt done");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
